// ===== design/adcc_ctrl.sv
// Converter control, status and result registers with trigger logic.
// Assumes an 8-bit register port on ref_clk, an analog core whose result
// is valid when its conversion ends, and trigger flags from same-clock logic.
`timescale 1ns/1ps
`default_nettype none

module adcc_ctrl
  import adcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic [6:0] trig_flags,
  input wire logic [9:0] core_result,
  input wire logic [15:0] pin_raw,
  output logic conv_irq,
  output adcc_core_t core,
  output logic [15:0] pin_read,
  output logic [15:0] din_disable
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  adcc_state_t s_q, s_d;     // Registered and next state
  logic psc_tick;            // Converter clock enable
  logic wr_a, wr_b, wr_m;    // Register writes
  logic rd_lo, rd_hi;        // Result byte reads
  logic sw_start;            // Software start request
  logic trig_sel;            // Selected trigger level
  logic auto_edge;           // Qualified trigger edge
  logic start;               // Conversion begins
  logic finish;              // Conversion ends
  logic free_next;           // Free-running restart
  logic [4:0] len;           // Length of running conversion
  logic [9:0] res_fmt;       // Result as presented
  logic flag_clr;            // Flag clear request

  // ----------------------------------------------------------------
  // Channel and gain decode
  // ----------------------------------------------------------------
  function automatic adcc_sel_t decode(input logic [5:0] m);
    adcc_sel_t s;
    s = '0;
    s.valid = 1'h1;
    case (m[4:3])
      2'b00: begin // Single ended
        s.pos = {m[5], m[2:0]};
      end
      2'b01: begin // Gain pairs
        s.diff = 1'h1;
        s.pos = {m[5], 1'h0, m[2], m[0]}; // R1
        s.neg = {m[5], 1'h0, m[2], 1'h0}; // R1
        s.gain = m[1] ? ADCC_GAIN_200X : ADCC_GAIN_10X; // R1
      end
      2'b10: begin // Unity gain against second pin
        s.diff = 1'h1;
        s.pos = {m[5], m[2:0]}; // R1
        s.neg = {m[5], 3'h1}; // R1
        s.gain = ADCC_GAIN_1X;
      end
      default: begin // Unity gain against third pin, top codes reserved
        if (m[2:1] == 2'b11) begin
          s.valid = 1'h0; // R1
        end else begin
          s.diff = 1'h1;
          s.pos = {m[5], m[2:0]}; // R1
          s.neg = {m[5], 3'h2}; // R1
          s.gain = ADCC_GAIN_1X;
        end
      end
    endcase
    return s;
  endfunction : decode

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  adcc_prescaler u_psc (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(s_q.en), // R23
    .div_sel(s_q.ps),
    .tick(psc_tick)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_a = 1'h0;
    wr_b = 1'h0;
    wr_m = 1'h0;
    rd_lo = 1'h0;
    rd_hi = 1'h0;
    if (bus_wr && bus_addr == ADCC_OFS_CTRL_A) begin
      wr_a = 1'h1;
    end else if (bus_wr && bus_addr == ADCC_OFS_CTRL_B) begin
      wr_b = 1'h1;
    end else if (bus_wr && bus_addr == ADCC_OFS_MUXSEL) begin
      wr_m = 1'h1;
    end else if (bus_rd && bus_addr == ADCC_OFS_RES_LO) begin
      rd_lo = 1'h1;
    end else if (bus_rd && bus_addr == ADCC_OFS_RES_HI) begin
      rd_hi = 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Start, trigger and finish conditions
  // ----------------------------------------------------------------
  always_comb begin
    // Write of one starts; zero does nothing
    sw_start = wr_a && bus_wdata[ADCC_A_SC]; // R3 R5
    // Selected flag; free running selects a constant low level
    trig_sel = (s_q.ts == ADCC_TS_FREE) ? 1'h0 : trig_flags[s_q.ts - 3'h1]; // R17 R18
    // Edge only counts with auto trigger on
    auto_edge = s_q.ate && trig_sel && !s_q.trig_prev; // R6 R15 R16
    len = s_q.run_init ? ADCC_INIT_TICKS : ADCC_NORM_TICKS; // R4
    finish = s_q.busy && psc_tick && (s_q.cnt == len - 5'h01); // R4
    free_next = s_q.ate && (s_q.ts == ADCC_TS_FREE); // R3
    // Enable as of the end of this cycle, so a joint write starts at once
    start = !s_q.busy && (wr_a ? bus_wdata[ADCC_A_EN] : s_q.en) && (sw_start || auto_edge); // R2 R16
    flag_clr = (wr_a && bus_wdata[ADCC_A_IF]) || irq_ack; // R8
  end

  // Result as returned by the core; differential made two's complement
  always_comb begin
    res_fmt = core_result;
    if (s_q.act[4:3] != 2'b00) begin
      res_fmt[9] = !core_result[9]; // R12
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Register writes
    if (wr_a) begin
      s_d.en = bus_wdata[ADCC_A_EN];
      s_d.ate = bus_wdata[ADCC_A_ATE];
      s_d.ie = bus_wdata[ADCC_A_IE];
      s_d.ps = bus_wdata[2:0];
      if (bus_wdata[ADCC_A_EN] && !s_q.en) begin
        s_d.first = 1'h1; // R4
      end
    end
    if (wr_b) begin
      s_d.cmp_mux = bus_wdata[ADCC_B_CMPMUX];
      s_d.mux[5] = bus_wdata[ADCC_B_CHTOP];
      s_d.ts = bus_wdata[2:0]; // Top bit not stored, reads zero
    end
    if (wr_m) begin
      s_d.left = bus_wdata[ADCC_M_LEFT];
      s_d.mux[4:0] = bus_wdata[4:0];
    end
    if (bus_wr && bus_addr == ADCC_OFS_DID_HI) begin
      s_d.did_hi = bus_wdata;
    end
    if (bus_wr && bus_addr == ADCC_OFS_DID_LO) begin
      s_d.did_lo = bus_wdata;
    end

    // Trigger history tracks the selected level every cycle
    s_d.trig_prev = trig_sel; // R16

    // Selection follows software only between conversions
    if (!s_q.busy) begin
      s_d.act = s_q.mux; // R22
    end

    // Conversion sequencing
    if (!s_d.en) begin
      s_d.busy = 1'h0; // R2
      s_d.cnt = '0;
    end else if (start) begin
      s_d.busy = 1'h1; // R3
      s_d.cnt = '0;
      s_d.run_init = s_d.first; // R4
      s_d.first = 1'h0;
      s_d.act = s_q.mux;
    end else if (finish) begin
      s_d.cnt = '0;
      s_d.run_init = 1'h0;
      s_d.act = s_q.mux; // R22
      s_d.busy = free_next; // R3
    end else if (s_q.busy && psc_tick) begin
      s_d.cnt = s_q.cnt + 5'h01;
    end

    // Done flag: clear first so that a set in the same cycle wins
    if (flag_clr) begin
      s_d.flag = 1'h0; // R8
    end
    if (finish && s_d.en) begin
      s_d.flag = 1'h1; // R7
      if (!s_q.lock) begin
        s_d.result = res_fmt; // R13
      end
    end

    // Read lock on the result bytes
    if (rd_lo) begin
      s_d.lock = 1'h1; // R13
    end else if (rd_hi) begin
      s_d.lock = 1'h0; // R13
    end

    // Interrupt request
    s_d.irq = s_d.flag && s_d.ie && global_irq_enable; // R9

    // Read data, held for the one cycle after a read
    s_d.rdata = ADCC_RST_BYTE;
    if (bus_rd) begin
      if (bus_addr == ADCC_OFS_RES_LO) begin
        s_d.rdata = s_q.left ? {s_q.result[1:0], 6'h00} : s_q.result[7:0]; // R11
      end else if (bus_addr == ADCC_OFS_RES_HI) begin
        s_d.rdata = s_q.left ? s_q.result[9:2] : {6'h00, s_q.result[9:8]}; // R11
      end else if (bus_addr == ADCC_OFS_CTRL_A) begin
        s_d.rdata = {s_q.en, s_q.busy, s_q.ate, s_q.flag, s_q.ie, s_q.ps}; // R5
      end else if (bus_addr == ADCC_OFS_CTRL_B) begin
        s_d.rdata = {1'h0, s_q.cmp_mux, 2'h0, s_q.mux[5], s_q.ts}; // R14
      end else if (bus_addr == ADCC_OFS_MUXSEL) begin
        s_d.rdata = {2'h0, s_q.left, s_q.mux[4:0]};
      end else if (bus_addr == ADCC_OFS_DID_HI) begin
        s_d.rdata = s_q.did_hi;
      end else if (bus_addr == ADCC_OFS_DID_LO) begin
        s_d.rdata = s_q.did_lo;
      end
    end

    // Pin inputs: two-stage synchroniser, then the disable mask
    s_d.pin_s1 = pin_raw;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_rd = s_q.pin_s2 & ~{s_q.did_hi, s_q.did_lo}; // R20 R21

    // Core side
    s_d.core.busy = s_d.busy;
    s_d.core.tick = s_q.busy && psc_tick;
    s_d.core.init = s_d.run_init;
    s_d.core.sel = decode(s_d.act); // R1
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, all from the state register
  assign bus_rdata = s_q.rdata;
  assign conv_irq = s_q.irq;
  assign core = s_q.core;
  assign pin_read = s_q.pin_rd;
  assign din_disable = {s_q.did_hi, s_q.did_lo};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Tick counter since the last start, for the length check
  logic [5:0] chk_ticks; // Ticks seen in the running conversion
  always_ff @(posedge ref_clk) begin
    if (rst || start) begin
      chk_ticks <= '0;
    end else if (s_q.busy && psc_tick) begin
      chk_ticks <= (finish) ? 6'h00 : chk_ticks + 6'h01;
    end
  end

  // Start of a conversion that must initialise, pending or enabled in the same write
  sequence q_start_init;
    start && (s_q.first || (wr_a && bus_wdata[ADCC_A_EN] && !s_q.en));
  endsequence

  sequence q_low_read;
    rd_lo;
  endsequence

  property p_len;
    finish |-> (chk_ticks == (s_q.run_init ? {1'h0, ADCC_INIT_TICKS - 5'h01} : {1'h0, ADCC_NORM_TICKS - 5'h01}));
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong"); // R4

  property p_init_flag;
    q_start_init |=> s_q.run_init && s_q.busy;
  endproperty
  a_init_flag: assert property (p_init_flag) else $error("first conversion not initialising"); // R4

  property p_abort;
    (wr_a && !bus_wdata[ADCC_A_EN]) |=> (!s_q.busy && !core.busy) ##1 (!core.busy || $past(start));
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort"); // R2

  property p_busy_read;
    (bus_rd && bus_addr == ADCC_OFS_CTRL_A) |=> bus_rdata[ADCC_A_SC] == $past(s_q.busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("start bit does not show busy"); // R5

  property p_flag_set;
    (finish && s_d.en) |=> s_q.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set"); // R7

  property p_flag_clr;
    (flag_clr && !finish) |=> !s_q.flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("done flag not cleared"); // R8

  property p_irq;
    conv_irq |-> $past(global_irq_enable) && s_q.ie && s_q.flag;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause"); // R9

  property p_lock_set;
    q_low_read |=> s_q.lock;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("low read did not lock"); // R13

  property p_lock;
    s_q.lock |=> $stable(s_q.result);
  endproperty
  a_lock: assert property (p_lock) else $error("locked result changed"); // R13

  property p_free_sel;
    (s_q.ts == ADCC_TS_FREE && !sw_start && !s_q.busy) |=> !s_q.busy;
  endproperty
  a_free_sel: assert property (p_free_sel) else $error("free running select triggered"); // R17

  property p_hold_sel;
    (s_q.busy && !finish) |=> $stable(s_q.act);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("selection changed mid conversion"); // R22

  property p_pin_mask;
    ##1 1'h1 |-> (pin_read & $past(din_disable)) == 16'h0000;
  endproperty
  a_pin_mask: assert property (p_pin_mask) else $error("disabled pin read as one"); // R20 R21

endmodule : adcc_ctrl

`default_nettype wire

// ===== design/adcc_pkg.sv
// Constants, register map and carrier types of the converter control block.
// Assumes one 200 MHz clock, a synchronous active-high reset and an 8-bit register port.
//
// What this block does
// R1 - Decode differential channel codes into pairs, gain
// R2 - Enable on; disable off, aborts running conversion
// R3 - Start bit begins single or first run
// R4 - First conversion 25 ticks, later 13
// R5 - Start bit reads busy; writing zero ignored
// R6 - Auto trigger starts on selected rising edge
// R7 - Done flag sets when result updated
// R8 - Done flag clears on vector or one-write
// R9 - Interrupt only with enable, global, flag
// R10 - Prescaler divides by 2 up to 128
// R11 - Result right or left aligned in bytes
// R12 - Differential results shown as two's complement
// R13 - Low byte read locks until high read
// R14 - Software writes zero to control B bit7
// R15 - Trigger select ignored unless auto trigger set
// R16 - Switching to a set source makes edge
// R17 - Switching to free running makes no edge
// R18 - Trigger codes map to fixed sources
// R19 - No free running with differential channels; not enforced, free running restarts on any channel
// R20 - Low disable bits mask low pin reads
// R21 - High disable bits mask high pin reads
// R22 - Channel change waits for conversion end
// R23 - Prescaler idle and cleared while disabled

package adcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCC_OFS_RES_LO = 8'h78;  // Result low byte
  localparam logic [7:0] ADCC_OFS_RES_HI = 8'h79;  // Result high byte
  localparam logic [7:0] ADCC_OFS_CTRL_A = 8'h7A;  // Control A
  localparam logic [7:0] ADCC_OFS_CTRL_B = 8'h7B;  // Control B
  localparam logic [7:0] ADCC_OFS_MUXSEL = 8'h7C;  // Channel low bits and alignment
  localparam logic [7:0] ADCC_OFS_DID_HI = 8'h7D;  // High pins input disable
  localparam logic [7:0] ADCC_OFS_DID_LO = 8'h7E;  // Low pins input disable

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ADCC_A_EN = 7;     // Converter enable
  localparam int ADCC_A_SC = 6;     // Start conversion
  localparam int ADCC_A_ATE = 5;    // Auto trigger enable
  localparam int ADCC_A_IF = 4;     // Conversion done flag
  localparam int ADCC_A_IE = 3;     // Done interrupt enable
  localparam int ADCC_B_CMPMUX = 6; // Comparator mux enable
  localparam int ADCC_B_CHTOP = 3;  // Channel select top bit
  localparam int ADCC_M_LEFT = 5;   // Left align

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCC_RST_BYTE = 8'h00;     // All registers
  localparam logic [9:0] ADCC_RST_RESULT = 10'h000; // Result word
  localparam logic [2:0] ADCC_TS_FREE = 3'h0;       // Free running code
  localparam logic [1:0] ADCC_GAIN_1X = 2'h0;
  localparam logic [1:0] ADCC_GAIN_10X = 2'h1;
  localparam logic [1:0] ADCC_GAIN_200X = 2'h2;

  // ----------------------------------------------------------------
  // Timing counts in converter clock ticks
  // ----------------------------------------------------------------
  localparam logic [4:0] ADCC_INIT_TICKS = 5'h19;   // 25, first conversion
  localparam logic [4:0] ADCC_NORM_TICKS = 5'h0D;   // 13, later conversions

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;        // Selection usable
    logic diff;         // Differential pair
    logic [3:0] pos;    // Positive input
    logic [3:0] neg;    // Negative input
    logic [1:0] gain;   // Gain code
  } adcc_sel_t;

  typedef struct packed {
    logic busy;         // Conversion running
    logic tick;         // Converter clock enable
    logic init;         // Initialising conversion
    adcc_sel_t sel;     // Active selection
  } adcc_core_t;

  typedef struct packed {
    logic [6:0] cnt;    // Divider count
    logic tick;         // Output enable pulse
  } adcc_psc_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic irq;
    logic en, busy, ate, flag, ie;
    logic [2:0] ps;
    logic cmp_mux;
    logic [2:0] ts;
    logic [5:0] mux;       // Software selection
    logic [5:0] act;       // Selection in use
    logic left;
    logic [7:0] did_lo, did_hi;
    logic first;           // Next start initialises
    logic run_init;        // Running conversion initialises
    logic [4:0] cnt;
    logic [9:0] result;
    logic lock;
    logic trig_prev;
    logic [15:0] pin_s1, pin_s2, pin_rd;
    adcc_core_t core;
  } adcc_state_t;

endpackage : adcc_pkg

// ===== design/adcc_prescaler.sv
// Converter clock prescaler: one-cycle enable pulses at the selected division.
// Assumes run and div_sel come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module adcc_prescaler
  import adcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);

  // ----------------------------------------------------------------
  // Divider state
  // ----------------------------------------------------------------
  adcc_psc_t s_q, s_d;  // Registered and next state
  logic [2:0] shift;    // Division as power of two
  logic [7:0] full;     // Division minus one, wide
  logic [6:0] term;     // Terminal count

  // Next-state logic
  always_comb begin
    shift = (div_sel < 3'h2) ? 3'h1 : div_sel;  // R10
    full = 8'(8'h01 << shift) - 8'h01;          // R10
    term = full[6:0];
    s_d = s_q;
    s_d.tick = 1'h0;
    if (!run) begin
      s_d.cnt = '0;                             // R23
    end else if (s_q.cnt >= term) begin         // A lower division takes effect at once
      s_d.cnt = '0;
      s_d.tick = 1'h1;                          // R10
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_div2;
    @(posedge ref_clk) disable iff (rst)
    (tick && run && div_sel < 3'h2 && $stable(div_sel)) ##1 (run && $stable(div_sel)) |=> tick;
  endproperty
  a_div2: assert property (p_div2) else $error("prescaler did not divide by two"); // R10

  property p_idle;
    @(posedge ref_clk) disable iff (rst)
    !run |=> (s_q.cnt == 7'h00) && !tick;
  endproperty
  a_idle: assert property (p_idle) else $error("prescaler ran while disabled"); // R23

endmodule : adcc_prescaler

`default_nettype wire

// ===== verification/adcc_core_model.sv
// Analog core stand-in: holds the level while converting.
// Assumes the result is sampled in the last busy cycle.
`timescale 1ns/1ps
`default_nettype none

module adcc_core_model
  import adcc_pkg::*;
(
  input wire logic ref_clk,
  input wire adcc_core_t core,
  input wire logic [9:0] level,
  output logic [9:0] core_result
);
  logic [9:0] held_q; // Level captured at start
  // Follow the level while idle, freeze it during a conversion
  always_ff @(posedge ref_clk) begin
    if (!core.busy) begin
      held_q <= level;
    end
  end
  // Idle output is not usable, so show the inverse
  assign core_result = core.busy ? held_q : ~held_q;
endmodule : adcc_core_model
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench of the converter control block.
// Assumes adcc_ctrl, the core model and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb
  import adcc_pkg::*;
;
  logic ref_clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, gie = 1'b0, irq_ack = 1'b0, conv_irq;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, rdata;
  logic [6:0] trig_flags = 7'h00; // Trigger sources
  logic [9:0] level = 10'h2A5, core_result; // Analog input level
  logic [15:0] pin_raw = 16'h0000, pin_read, din_disable;
  adcc_core_t core;
  adcc_sel_t e; // Expected selection
  int mismatches = 0, tests_run = 0, cyc = 0, ticks = 0, gap = 0;

  always #2.5 ref_clk = ~ref_clk;

  adcc_ctrl uut (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(rdata), .global_irq_enable(gie),
    .irq_ack(irq_ack), .trig_flags(trig_flags), .core_result(core_result), .pin_raw(pin_raw),
    .conv_irq(conv_irq), .core(core), .pin_read(pin_read), .din_disable(din_disable));
  adcc_core_model model (.ref_clk(ref_clk), .core(core), .level(level), .core_result(core_result));

  // Tick counter and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (core.tick === 1'b1) ticks++;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Bus and wait helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] x, input string nm);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(nm, x, rdata)
  endtask : rdc

  // Run until idle, measuring spacing of the first two ticks
  task automatic wait_done();
    int c;
    int n;
    c = 0;
    n = 0;
    while (core.busy === 1'b1) begin
      if (core.tick === 1'b1) begin
        if (n == 1) gap = c;
        n++;
        c = 0;
      end
      @(posedge ref_clk);
      #1;
      c++;
    end
    // One more edge so the final tick is counted
    @(posedge ref_clk);
    #1;
  endtask : wait_done

  task automatic conv(input logic [7:0] a);
    ticks = 0;
    wr(8'h7A, a);
    wait_done();
  endtask : conv

  task automatic set_trig(input logic [6:0] v);
    @(posedge ref_clk);
    trig_flags <= v;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : set_trig

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ofs [8] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h70};
    foreach (ofs[i]) rdc(ofs[i], 8'h00, "reset value");
    `CHK("irq", 1'b0, conv_irq)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_single();
    wr(8'h7A, 8'h80);
    wr(8'h7A, 8'h80);
    `CHK("zero start", 1'b0, core.busy)
    conv(8'hC0);
    `CHK("first ticks", 25, ticks)
    rdc(8'h7A, 8'h90, "idle status");
    rdc(8'h78, 8'hA5, "right low");
    rdc(8'h79, 8'h02, "right high");
    wr(8'h7A, 8'hD0);
    rdc(8'h7A, 8'hC0, "busy status");
    wait_done();
    for (int p = 0; p < 8; p++) begin
      conv(8'hD0 | 8'(p));
      `CHK("later ticks", 13, ticks)
      `CHK("divide", (p < 2) ? 2 : (1 << p), gap)
    end
    $display("t_single done");
  endtask : t_single

  task automatic t_lock();
    wr(8'h7C, 8'h20);
    rdc(8'h79, 8'hA9, "left high");
    rdc(8'h78, 8'h40, "left low");
    level = 10'h15A;
    conv(8'hD0);
    rdc(8'h79, 8'hA9, "locked high");
    conv(8'hD0);
    rdc(8'h79, 8'h56, "unlocked high");
    level = 10'h3FF;
    conv(8'hD0);
    rdc(8'h79, 8'hFF, "high only");
    wr(8'h7C, 8'h00);
    $display("t_lock done");
  endtask : t_lock

  task automatic t_irq();
    wr(8'h7A, 8'h88);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("irq masked", 1'b0, conv_irq)
    @(posedge ref_clk);
    gie <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq raised", 1'b1, conv_irq)
    @(posedge ref_clk);
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq acked", 1'b0, conv_irq)
    rdc(8'h7A, 8'h88, "acked status");
    wr(8'h7A, 8'hC0);
    `CHK("later init", 1'b0, core.init)
    repeat (6) @(posedge ref_clk);
    wr(8'h7A, 8'h00);
    `CHK("abort busy", 1'b0, core.busy)
    repeat (60) @(posedge ref_clk);
    rdc(8'h7A, 8'h00, "abort flag");
    ticks = 0;
    wr(8'h7A, 8'hC0);
    `CHK("first init", 1'b1, core.init)
    wait_done();
    `CHK("reenable ticks", 25, ticks)
    $display("t_irq done");
  endtask : t_irq

  task automatic t_trig();
    for (int s = 1; s < 8; s++) begin
      wr(8'h7A, 8'hB0);
      wr(8'h7B, 8'(s));
      set_trig(~(7'h01 << (s - 1)));
      `CHK("other source", 1'b0, core.busy)
      set_trig(7'h7F);
      `CHK("selected source", 1'b1, core.busy)
      wait_done();
      set_trig(7'h00);
    end
    wr(8'h7A, 8'h90);
    wr(8'h7B, 8'h01);
    set_trig(7'h01);
    `CHK("auto off", 1'b0, core.busy)
    set_trig(7'h02);
    wr(8'h7A, 8'hB0);
    wr(8'h7B, 8'h02);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("switch edge", 1'b1, core.busy)
    wait_done();
    wr(8'h7B, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("free no edge", 1'b0, core.busy)
    wr(8'h7A, 8'hF0);
    repeat (40) @(posedge ref_clk);
    rdc(8'h7A, 8'hF0, "free running");
    wr(8'h7A, 8'h90);
    wait_done();
    set_trig(7'h00);
    $display("t_trig done");
  endtask : t_trig

  task automatic t_chan();
    logic [5:0] c;
    for (int k = 40; k < 64; k++) begin
      c = 6'(k);
      e.valid = (k < 62);
      e.diff = 1'b1;
      e.pos = (c[5:3] == 3'h5) ? 4'(8 + c[0] + 2 * c[2]) : 4'(8 + c[2:0]);
      e.neg = (c[5:3] == 3'h5) ? 4'(8 + 2 * c[2]) : (c[3] ? 4'hA : 4'h9);
      e.gain = (c[5:3] != 3'h5) ? ADCC_GAIN_1X : (c[1] ? ADCC_GAIN_200X : ADCC_GAIN_10X);
      wr(8'h7B, 8'h08);
      wr(8'h7C, {3'h0, c[4:0]});
      wr(8'h7A, 8'hD0);
      repeat (2) @(posedge ref_clk);
      #1;
      if (e.valid) `CHK("selection", e, core.sel)
      else `CHK("reserved", 1'b0, core.sel.valid)
      wait_done();
    end
    level = 10'h2A5;
    wr(8'h7C, 8'h10);
    wr(8'h7A, 8'hD0);
    wr(8'h7C, 8'h11);
    `CHK("held pos", 4'h8, core.sel.pos)
    wait_done();
    rdc(8'h78, 8'hA5, "diff low");
    rdc(8'h79, 8'h00, "diff high");
    wr(8'h7A, 8'hD0);
    `CHK("new pos", 4'h9, core.sel.pos)
    wait_done();
    wr(8'h7B, 8'h00);
    wr(8'h7C, 8'h00);
    $display("t_chan done");
  endtask : t_chan

  task automatic t_pins();
    @(posedge ref_clk);
    pin_raw <= 16'hFFFF;
    wr(8'h7E, 8'h0F);
    wr(8'h7D, 8'hF0);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("pin read", 16'h0FF0, pin_read)
    `CHK("disable out", 16'hF00F, din_disable)
    rdc(8'h7D, 8'hF0, "high disable reg");
    $display("t_pins done");
  endtask : t_pins

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // Reset, then run every scenario
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_lock();
    t_irq();
    t_trig();
    t_chan();
    t_pins();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
